// ==== logic/prsr_defs.svh ====
// register offsets, field positions and reset values for the peripheral soft reset block
`ifndef PRSR_DEFS_SVH
`define PRSR_DEFS_SVH

`define PRSR_OFF_SERIAL_TIMERS  12'h044
`define PRSR_OFF_PORT           12'h048
`define PRSR_ADDR_BITS          12
`define PRSR_WORD_LSB           2

`define PRSR_BIT_SERIAL_ZERO    0
`define PRSR_BIT_SERIAL_ONE     1
`define PRSR_BIT_SYNC_SERIAL    4
`define PRSR_BIT_TWO_WIRE       12
`define PRSR_BIT_TIMER_ZERO     16
`define PRSR_BIT_TIMER_ONE      17
`define PRSR_BIT_TIMER_TWO      18
`define PRSR_BIT_COMPARATOR     24
`define PRSR_NUM_PORTS          5

// implemented (writable) bits of each register; everything else reads zero
`define PRSR_IMPL_SERIAL_TIMERS 32'h0107_1013
`define PRSR_IMPL_PORT          32'h0000_001F
`define PRSR_RST_SERIAL_TIMERS  32'h0000_0000
`define PRSR_RST_PORT           32'h0000_0000
`define PRSR_ZERO_WORD          32'h0000_0000

`define PRSR_HTRANS_NONSEQ      2'h2
`define PRSR_HTRANS_SEQ         2'h3
`define PRSR_HRESP_OKAY         1'h0

`endif

// ==== logic/prsr_pkg.sv ====
// types shared by the peripheral soft reset block
package prsr_pkg;
    typedef enum logic [1:0] {
        PRSR_SEL_NONE   = 2'b00,
        PRSR_SEL_SERIAL = 2'b01,
        PRSR_SEL_PORT   = 2'b10
    } prsr_sel_t;
endpackage

// ==== logic/prsr_ctl_reg.sv ====
// one masked read-write reset control register
`include "prsr_defs.svh"

module prsr_ctl_reg
    import prsr_pkg::*;
#(
    parameter logic [31:0] IMPL_MASK = `PRSR_IMPL_SERIAL_TIMERS,
    parameter logic [31:0] RST_VAL   = `PRSR_RST_SERIAL_TIMERS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [31:0] cap_mask,
    output logic      [31:0] value
);
    logic [31:0] value_reg;
    logic [31:0] value_next;
    logic [31:0] wr_mask;

    // capability and implementation both gate a bit; others keep their value
    assign wr_mask    = IMPL_MASK & cap_mask;
    assign value_next = (value_reg & ~wr_mask) | (wr_data & wr_mask);
    assign value      = value_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_reg <= RST_VAL;
        end else if (clk_en && wr_en) begin
            value_reg <= value_next;
        end
    end
endmodule

// ==== logic/prsr_top.sv ====
// peripheral soft reset control registers on an AHB-Lite slave port
//
// Summary of operation
// - serial/timer register writes only touch bits present in capability mask two
// - port register writes only touch bits present in capability mask four
// - bits 1 and 0 reset serial ports one and zero, read-write, reset 0
// - bit 4 resets synchronous serial unit zero, read-write, reset 0
// - bit 12 resets two-wire unit zero, read-write, reset 0
// - port register bits 0..4 reset ports A..E, read-write, reset 0
// - port register comes out of reset as all zeros
// - reserved bits read zero and ignore writes
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "prsr_defs.svh"

module prsr_top
    import prsr_pkg::*;
#(
    parameter int NUM_PORTS = `PRSR_NUM_PORTS
) (
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 clk_en,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic [31:0]          capability_mask_second,
    input  wire logic [31:0]          capability_mask_fourth,
    output logic                      serial_port_zero_reset,
    output logic                      serial_port_one_reset,
    output logic                      sync_serial_zero_reset,
    output logic                      two_wire_zero_reset,
    output logic                      timer_zero_reset,
    output logic                      timer_one_reset,
    output logic                      timer_two_reset,
    output logic                      comparator_zero_reset,
    output logic [NUM_PORTS-1:0]      port_reset
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    // the release chain ignores clk_en so that a reset always ends on its own
    logic rst_sync1_reg;
    logic rst_n_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1_reg <= 1'b0;
            rst_n_reg     <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n_reg     <= rst_sync1_reg;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic prsr_sel_t decode(input logic [31:0] addr);
        logic [`PRSR_ADDR_BITS-1:0] off;
        off = addr[`PRSR_ADDR_BITS-1:0];
        if (off == `PRSR_OFF_SERIAL_TIMERS) begin
            decode = PRSR_SEL_SERIAL;
        end else if (off == `PRSR_OFF_PORT) begin
            decode = PRSR_SEL_PORT;
        end else begin
            decode = PRSR_SEL_NONE;
        end
    endfunction

    logic      addr_valid;
    logic      wr_pend_reg;
    prsr_sel_t wr_sel_reg;
    logic      wr_serial;
    logic      wr_port;

    assign addr_valid = hsel && hready && clk_en &&
                        (htrans == `PRSR_HTRANS_NONSEQ || htrans == `PRSR_HTRANS_SEQ);

    // the write lands in the data phase; the slave never stalls, so zero wait states
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_pend_reg <= 1'b0;
            wr_sel_reg  <= PRSR_SEL_NONE;
        end else if (clk_en) begin
            wr_pend_reg <= addr_valid && hwrite;
            wr_sel_reg  <= addr_valid ? decode(haddr) : PRSR_SEL_NONE;
        end
    end

    assign wr_serial = wr_pend_reg && (wr_sel_reg == PRSR_SEL_SERIAL);
    assign wr_port   = wr_pend_reg && (wr_sel_reg == PRSR_SEL_PORT);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [31:0] serial_val;
    logic [31:0] port_val;

    prsr_ctl_reg #(
        .IMPL_MASK (`PRSR_IMPL_SERIAL_TIMERS),
        .RST_VAL   (`PRSR_RST_SERIAL_TIMERS)
    ) u_serial_timers (
        .clk      (clk),
        .rst_n    (rst_n_reg),
        .clk_en   (clk_en),
        .wr_en    (wr_serial),
        .wr_data  (hwdata),
        .cap_mask (capability_mask_second),
        .value    (serial_val)
    );

    prsr_ctl_reg #(
        .IMPL_MASK (`PRSR_IMPL_PORT),
        .RST_VAL   (`PRSR_RST_PORT)
    ) u_port (
        .clk      (clk),
        .rst_n    (rst_n_reg),
        .clk_en   (clk_en),
        .wr_en    (wr_port),
        .wr_data  (hwdata),
        .cap_mask (capability_mask_fourth),
        .value    (port_val)
    );

    // ----------------------------------------------------------------
    // bus answer
    // ----------------------------------------------------------------
    // read data registered in the address phase; a write in the previous data
    // phase to the same register is caught by forwarding its next value
    logic [31:0] serial_fwd;
    logic [31:0] port_fwd;

    assign serial_fwd = wr_serial ? (serial_val & ~(`PRSR_IMPL_SERIAL_TIMERS &
                        capability_mask_second)) | (hwdata & `PRSR_IMPL_SERIAL_TIMERS &
                        capability_mask_second) : serial_val;
    assign port_fwd   = wr_port ? (port_val & ~(`PRSR_IMPL_PORT & capability_mask_fourth))
                        | (hwdata & `PRSR_IMPL_PORT & capability_mask_fourth) : port_val;

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hrdata <= `PRSR_ZERO_WORD;
        end else if (clk_en) begin
            if (addr_valid && !hwrite && decode(haddr) == PRSR_SEL_SERIAL) begin
                hrdata <= serial_fwd;
            end else if (addr_valid && !hwrite && decode(haddr) == PRSR_SEL_PORT) begin
                hrdata <= port_fwd;
            end else begin
                hrdata <= `PRSR_ZERO_WORD;
            end
        end
    end

    // unmapped addresses read zero and complete OKAY
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hreadyout <= 1'b1;
            hresp     <= `PRSR_HRESP_OKAY;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp     <= `PRSR_HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // peripheral reset outputs
    // ----------------------------------------------------------------
    // registered once more so every output is a flop; costs one cycle of latency
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            serial_port_zero_reset <= 1'b0;
            serial_port_one_reset  <= 1'b0;
            sync_serial_zero_reset <= 1'b0;
            two_wire_zero_reset    <= 1'b0;
            timer_zero_reset       <= 1'b0;
            timer_one_reset        <= 1'b0;
            timer_two_reset        <= 1'b0;
            comparator_zero_reset  <= 1'b0;
        end else if (clk_en) begin
            serial_port_zero_reset <= serial_val[`PRSR_BIT_SERIAL_ZERO];
            serial_port_one_reset  <= serial_val[`PRSR_BIT_SERIAL_ONE];
            sync_serial_zero_reset <= serial_val[`PRSR_BIT_SYNC_SERIAL];
            two_wire_zero_reset    <= serial_val[`PRSR_BIT_TWO_WIRE];
            timer_zero_reset       <= serial_val[`PRSR_BIT_TIMER_ZERO];
            timer_one_reset        <= serial_val[`PRSR_BIT_TIMER_ONE];
            timer_two_reset        <= serial_val[`PRSR_BIT_TIMER_TWO];
            comparator_zero_reset  <= serial_val[`PRSR_BIT_COMPARATOR];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            always_ff @(posedge clk or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    port_reset[gi] <= 1'b0;
                end else if (clk_en) begin
                    port_reset[gi] <= port_val[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SERIAL_MASKED: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && wr_serial) |=> ((serial_val ^ $past(serial_val)) &
        ~($past(capability_mask_second) & `PRSR_IMPL_SERIAL_TIMERS)) == 32'h0000_0000)
        else $error("serial register bit changed outside capability mask");

    AST_PORT_MASKED: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && wr_port) |=> ((port_val ^ $past(port_val)) &
        ~($past(capability_mask_fourth) & `PRSR_IMPL_PORT)) == 32'h0000_0000)
        else $error("port register bit changed outside capability mask");

    AST_SERIAL_WRITE: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && wr_serial && capability_mask_second[`PRSR_BIT_SERIAL_ZERO])
        |=> serial_val[`PRSR_BIT_SERIAL_ZERO] == $past(hwdata[`PRSR_BIT_SERIAL_ZERO]))
        else $error("serial port zero bit did not take written value");

    AST_SYNC_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> sync_serial_zero_reset == $past(serial_val[`PRSR_BIT_SYNC_SERIAL]))
        else $error("sync serial reset output mismatch");

    AST_TWO_WIRE_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> two_wire_zero_reset == $past(serial_val[`PRSR_BIT_TWO_WIRE]))
        else $error("two-wire reset output mismatch");

    AST_PORT_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> port_reset == $past(port_val[NUM_PORTS-1:0]))
        else $error("port reset outputs mismatch");

    AST_PORT_RESET_ZERO: assert property (@(posedge clk)
        $rose(rst_n_reg) |-> port_val == `PRSR_RST_PORT)
        else $error("port register not zero after reset");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_n_reg)
        ((serial_val & ~`PRSR_IMPL_SERIAL_TIMERS) == 32'h0000_0000) &&
        ((port_val & ~`PRSR_IMPL_PORT) == 32'h0000_0000) &&
        ((hrdata & ~(`PRSR_IMPL_SERIAL_TIMERS | `PRSR_IMPL_PORT)) == 32'h0000_0000))
        else $error("reserved bit not zero");

    AST_TIMER_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> {comparator_zero_reset, timer_two_reset, timer_one_reset} ==
        {$past(serial_val[`PRSR_BIT_COMPARATOR]), $past(serial_val[`PRSR_BIT_TIMER_TWO]),
         $past(serial_val[`PRSR_BIT_TIMER_ONE])})
        else $error("timer or comparator reset output mismatch");

    AST_HOLD_IN_RESET: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && serial_val[`PRSR_BIT_TIMER_ZERO] && !wr_serial) [*2]
        |-> timer_zero_reset)
        else $error("timer zero released while control bit set");

    AST_SERIAL_RESET_ZERO: assert property (@(posedge clk)
        $rose(rst_n_reg) |-> serial_val == `PRSR_RST_SERIAL_TIMERS)
        else $error("serial register not zero after reset");

    AST_SERIAL_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> {serial_port_one_reset, serial_port_zero_reset} ==
        {$past(serial_val[`PRSR_BIT_SERIAL_ONE]), $past(serial_val[`PRSR_BIT_SERIAL_ZERO])})
        else $error("serial port reset outputs mismatch");

    AST_TIMER_ZERO_OUT: assert property (@(posedge clk) disable iff (!rst_n_reg)
        clk_en |=> timer_zero_reset == $past(serial_val[`PRSR_BIT_TIMER_ZERO]))
        else $error("timer zero reset output mismatch");

    // every allowed bit must take the written value, not merely stay put elsewhere
    AST_SERIAL_TAKES: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && wr_serial) |=> ((serial_val ^ $past(hwdata)) &
        $past(capability_mask_second) & `PRSR_IMPL_SERIAL_TIMERS) == `PRSR_ZERO_WORD)
        else $error("serial register bit did not take written value");

    AST_PORT_TAKES: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && wr_port) |=> ((port_val ^ $past(hwdata)) &
        $past(capability_mask_fourth) & `PRSR_IMPL_PORT) == `PRSR_ZERO_WORD)
        else $error("port register bit did not take written value");

    AST_PORT_HOLD: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (clk_en && !wr_port) [*2] |->
        (port_reset & $past(port_val[NUM_PORTS-1:0])) == $past(port_val[NUM_PORTS-1:0]))
        else $error("port released while control bit set");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_n_reg)
        (addr_valid && !hwrite && decode(haddr) == PRSR_SEL_NONE) |=>
        hrdata == `PRSR_ZERO_WORD)
        else $error("unmapped read returned nonzero data");

    // a frozen block must neither store a write nor move an output
    AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n_reg)
        !clk_en |=> $stable(serial_val) && $stable(port_val) && $stable(port_reset) &&
        $stable(timer_zero_reset) && $stable(hrdata))
        else $error("state changed while clock enable low");

    AST_OUTPUTS_CLEAR: assert property (@(posedge clk)
        $rose(rst_n_reg) |-> (port_reset == {NUM_PORTS{1'b0}}) && !serial_port_zero_reset &&
        !timer_zero_reset && !comparator_zero_reset)
        else $error("reset outputs not clear after reset");

    AST_BUS_OKAY: assert property (@(posedge clk) disable iff (!rst_n_reg)
        hreadyout && hresp == `PRSR_HRESP_OKAY)
        else $error("bus answer not ready or not okay");
endmodule

// ==== test/prsr_top_tb_top.sv ====
// self-checking bench for the peripheral soft reset registers
`include "prsr_defs.svh"

module prsr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    localparam logic [11:0] OFF_ST   = 12'h044;
    localparam logic [11:0] OFF_PT   = 12'h048;
    localparam logic [11:0] OFF_NONE = 12'h04C;
    // bits 24, 18..16, 12, 4, 1, 0 are the only storage in the serial/timer word
    localparam logic [31:0] IMPL_ST  = 32'h0107_1013;

    logic        clk     = 1'b0;
    // nrst starts high so the time-zero drop is a real edge into the async reset
    logic        nrst    = 1'b1;
    logic        clk_en  = 1'b1;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] mask2   = 32'hFFFF_FFFF;
    logic [31:0] mask4   = 32'hFFFF_FFFF;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         s0, s1, ss, tw, t0, t1, t2, cz;
    wire  [4:0]  port_reset;
    int          errors    = 0;
    int          tests_run = 0;

    // reset outputs laid out on their register bit positions
    wire  [31:0] st_view = {7'h0, cz, 5'h0, t2, t1, t0, 3'h0, tw, 7'h0, ss, 2'h0, s1, s0};
    wire  [31:0] pt_view = {27'h0, port_reset};

    always #12.5 clk = ~clk;

    prsr_top DUT (
        .clk                    (clk),
        .nrst                   (nrst),
        .clk_en                 (clk_en),
        .hsel                   (hsel),
        .haddr                  (haddr),
        .htrans                 (htrans),
        .hwrite                 (hwrite),
        .hsize                  (3'h2),
        .hwdata                 (hwdata),
        .hready                 (hreadyout),
        .hrdata                 (hrdata),
        .hreadyout              (hreadyout),
        .hresp                  (hresp),
        .capability_mask_second (mask2),
        .capability_mask_fourth (mask4),
        .serial_port_zero_reset (s0),
        .serial_port_one_reset  (s1),
        .sync_serial_zero_reset (ss),
        .two_wire_zero_reset    (tw),
        .timer_zero_reset       (t0),
        .timer_one_reset        (t1),
        .timer_two_reset        (t2),
        .comparator_zero_reset  (cz),
        .port_reset             (port_reset)
    );

    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic summarize;
        if (errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // ready is looked at in the active region, before the edge's own updates land
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            if (n == 20) begin
                check_word("hreadyout", 32'h1, {31'h0, hreadyout});
                summarize();
            end
            n++;
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic [11:0] off, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr  <= {20'h0_0000, off};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel   <= 1'b1;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check_word("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        logic [31:0] x;
        bus(off, 1'b1, d, x);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] off, input logic [31:0] exp);
        logic [31:0] x;
        bus(off, 1'b0, 32'h0000_0000, x);
        check_word(name, exp, x);
    endtask

    // outputs trail the register by one clock
    task automatic outs_chk(input logic [31:0] exp_st, input logic [31:0] exp_pt);
        repeat (2) @(posedge clk);
        check_word("serial outputs", exp_st, st_view);
        check_word("port outputs", exp_pt, pt_view);
    endtask

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset_values;
        rd_chk("serial after reset", OFF_ST, 32'h0000_0000);
        rd_chk("port after reset", OFF_PT, 32'h0000_0000);
        outs_chk(32'h0000_0000, 32'h0000_0000);
    endtask

    // walking one over every position, read back right behind the write
    task automatic sc_serial_bits;
        for (int i = 0; i < 32; i++) begin
            wr(OFF_ST, 32'h0000_0001 << i);
            rd_chk("serial bit", OFF_ST, (32'h0000_0001 << i) & IMPL_ST);
        end
        wr(OFF_ST, 32'hFFFF_FFFF);
        outs_chk(IMPL_ST, 32'h0000_0000);
        wr(OFF_ST, 32'h0000_0000);
        outs_chk(32'h0000_0000, 32'h0000_0000);
    endtask

    task automatic sc_serial_mask;
        mask2 <= 32'h0000_1010;
        wr(OFF_ST, 32'hFFFF_FFFF);
        rd_chk("serial masked set", OFF_ST, 32'h0000_1010);
        mask2 <= 32'h0000_0010;
        wr(OFF_ST, 32'h0000_0000);
        rd_chk("serial masked clear", OFF_ST, 32'h0000_1000);
        outs_chk(32'h0000_1000, 32'h0000_0000);
        mask2 <= 32'hFFFF_FFFF;
    endtask

    task automatic sc_port;
        wr(OFF_PT, 32'hFFFF_FFFF);
        rd_chk("port all set", OFF_PT, 32'h0000_001F);
        outs_chk(32'h0000_1000, 32'h0000_001F);
        mask4 <= 32'h0000_0005;
        wr(OFF_PT, 32'h0000_0000);
        rd_chk("port masked clear", OFF_PT, 32'h0000_001A);
        outs_chk(32'h0000_1000, 32'h0000_001A);
        mask4 <= 32'hFFFF_FFFF;
    endtask

    task automatic sc_unmapped;
        wr(OFF_NONE, 32'hFFFF_FFFF);
        rd_chk("unmapped", OFF_NONE, 32'h0000_0000);
        rd_chk("port kept", OFF_PT, 32'h0000_001A);
        rd_chk("serial kept", OFF_ST, 32'h0000_1000);
    endtask

    // a low clock enable must keep the outputs on the old register value
    task automatic sc_freeze;
        wr(OFF_PT, 32'h0000_0003);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        check_word("frozen port outputs", 32'h0000_001A, pt_view);
        clk_en <= 1'b1;
        outs_chk(32'h0000_1000, 32'h0000_0003);
        rd_chk("port after freeze", OFF_PT, 32'h0000_0003);
    endtask

    task automatic sc_midrun_reset;
        do_reset();
        rd_chk("serial after second reset", OFF_ST, 32'h0000_0000);
        rd_chk("port after second reset", OFF_PT, 32'h0000_0000);
        outs_chk(32'h0000_0000, 32'h0000_0000);
    endtask

    initial begin
        do_reset();
        sc_reset_values();
        sc_serial_bits();
        sc_serial_mask();
        sc_port();
        sc_unmapped();
        sc_freeze();
        sc_midrun_reset();
        summarize();
    end
endmodule
